// file: verilog/serdes21_pkg.sv
// constants, types and slot timing helper for the 21-bit serial link
// Functional notes
// - the transmitter takes in all 21 parallel bits on every rising edge of its parallel input clock.
// - the transmitter sends that word on three serial pairs, each with a true and a complement line.
// - the transmitter forwards its clock on one extra pair that runs beside the data pairs.
// - with its power-down input low, the transmitter floats every serial data and clock output.
// - the receiver takes three serial data pairs and one forwarded clock pair as its link inputs.
// - the receiver presents 21 parallel bits and an output clock whose rising edge strobes them.
// - while the receiver is powered down its parallel outputs stay at the values they held before.
// - each serial pair carries seven bits per input clock period, each one seventh of the period long.
// - power-down is active low, may come at any time, and outputs toggle again about 10 ms after release.
// - when the forwarded clock stops, the receiver clocks stop and its outputs keep their last states.
package serdes21_pkg;
  localparam int NUM_BITS       = 21;
  localparam int NUM_PAIRS      = 3;
  localparam int SLOTS_PER_PAIR = 7;
  localparam int PERIOD_W       = 8;
  localparam int ACC_W          = 9;
  localparam int SYNC_W         = 32;
  localparam int CLK_FREQ_HZ    = 100_000_000;
  localparam int LOCK_TIME_MS   = 10;
  localparam int LOCK_CYCLES    = LOCK_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int TX_SIDE        = 0;
  localparam int RX_SIDE        = 1;

  localparam logic [2:0]          FIRST_SLOT   = 3'h0;
  localparam logic [2:0]          STROBE_SLOT  = 3'h3;
  localparam logic [2:0]          LAST_SLOT    = 3'h6;
  localparam logic [ACC_W-1:0]    ACC_STEP     = 9'h007;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h0E;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX   = 8'hFF;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE   = 8'h01;

  // power and lock progress, gray coded
  typedef enum logic [1:0] {
    LINK_OFF     = 2'b00,
    LINK_LOCKING = 2'b01,
    LINK_ACTIVE  = 2'b11
  } link_state_t;

  // fractional slot timer: seven slots spread over one measured period
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [2:0]       slot;
    logic             run;
    logic             tick;
  } slot_timer_t;

  // add seven per cycle, leave a slot each time the period is passed
  function automatic slot_timer_t timer_step(input slot_timer_t t, input logic [PERIOD_W-1:0] period);
    slot_timer_t      n;
    logic [ACC_W-1:0] sum;
    n      = t;
    n.tick = 1'b0;
    sum    = t.acc + ACC_STEP;
    if (t.run) begin
      n.acc = sum;
      if (sum >= {1'b0, period}) begin
        n.acc  = sum - {1'b0, period};
        n.tick = 1'b1;
        if (t.slot == LAST_SLOT) begin
          n.run = 1'b0;
        end else begin
          n.slot = t.slot + 3'h1;
        end
      end
    end
    return n;
  endfunction
endpackage

// file: verilog/serdes21.sv
// transmitter and receiver halves of the 21-bit, three-pair serial link
`timescale 1ns/1ps
module serdes21
  import serdes21_pkg::*;
#(
  parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 parallel_input_clock,
  input  wire logic [NUM_BITS-1:0]  parallel_tx_inputs,
  input  wire logic                 tx_power_down_n,
  output logic      [NUM_PAIRS-1:0] serial_data_pair_true,
  output logic      [NUM_PAIRS-1:0] serial_data_pair_comp,
  output logic                      serial_data_oe,
  output logic                      forwarded_clock_true,
  output logic                      forwarded_clock_comp,
  output logic                      forwarded_clock_oe,
  input  wire logic [NUM_PAIRS-1:0] link_data_in_true,
  input  wire logic [NUM_PAIRS-1:0] link_data_in_comp,
  input  wire logic                 link_clock_in_true,
  input  wire logic                 link_clock_in_comp,
  input  wire logic                 rx_power_down_n,
  output logic      [NUM_BITS-1:0]  parallel_rx_outputs,
  output logic                      recovered_output_clock
);
  localparam int LOCK_W = $clog2(LOCK_CYCLES_P + 1);

  logic [SYNC_W-1:0]    meta_ff;
  logic [SYNC_W-1:0]    sync_ff;
  logic [NUM_BITS-1:0]  tx_data_s;
  logic                 tx_clk_s;
  logic [NUM_PAIRS-1:0] rx_t_s;
  logic [NUM_PAIRS-1:0] rx_c_s;
  logic                 rx_clk_s;
  logic [1:0]           pd_n_s;
  link_state_t          link_state_ff [2];
  logic [LOCK_W-1:0]    lock_cnt_ff [2];
  logic                 tx_clk_d_ff;
  logic                 tx_edge;
  logic [PERIOD_W-1:0]  tx_cnt_ff;
  logic [PERIOD_W-1:0]  tx_period_ff;
  slot_timer_t          tx_tmr_ff;
  slot_timer_t          nxt_tx_tmr;
  logic [NUM_BITS-1:0]  word_ff;
  logic [NUM_BITS-1:0]  nxt_word;
  logic [NUM_PAIRS-1:0] nxt_tx_bits;
  logic [NUM_PAIRS-1:0] serial_data_pair_true_ff;
  logic [NUM_PAIRS-1:0] serial_data_pair_comp_ff;
  logic                 serial_data_oe_ff;
  logic                 forwarded_clock_true_ff;
  logic                 forwarded_clock_comp_ff;
  logic                 forwarded_clock_oe_ff;
  logic                 rx_clk_d_ff;
  logic                 rx_edge;
  logic [PERIOD_W-1:0]  rx_cnt_ff;
  logic [PERIOD_W-1:0]  rx_period_ff;
  slot_timer_t          rx_tmr_ff;
  slot_timer_t          nxt_rx_tmr;
  logic [NUM_PAIRS-1:0] rx_bit;
  logic [NUM_BITS-1:0]  rx_shift_ff;
  logic [NUM_BITS-1:0]  nxt_rx_shift;
  logic                 rx_word_done;
  logic [NUM_BITS-1:0]  parallel_rx_outputs_ff;
  logic                 recovered_output_clock_ff;

  // two-stage synchroniser for every pin from outside the clk domain
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {parallel_tx_inputs, parallel_input_clock, tx_power_down_n, link_data_in_true,
                  link_data_in_comp, link_clock_in_true, link_clock_in_comp, rx_power_down_n};
      sync_ff <= meta_ff;
    end
  end

  // synchronised pin fields
  assign tx_data_s = sync_ff[31:11];
  assign tx_clk_s  = sync_ff[10];
  assign pd_n_s    = {sync_ff[0], sync_ff[9]};
  assign rx_t_s    = sync_ff[8:6];
  assign rx_c_s    = sync_ff[5:3];
  assign rx_clk_s  = sync_ff[2] & ~sync_ff[1];

  // power-down and lock wait, one machine per half
  for (genvar i = 0; i < 2; i++) begin : g_lock
    always_ff @(posedge clk) begin
      if (rst) begin
        link_state_ff[i] <= LINK_OFF;
        lock_cnt_ff[i]   <= '0;
      end else begin
        lock_cnt_ff[i] <= '0;
        case (link_state_ff[i])
          LINK_OFF: begin
            if (pd_n_s[i]) begin
              link_state_ff[i] <= LINK_LOCKING;
            end
          end
          LINK_LOCKING: begin
            lock_cnt_ff[i] <= lock_cnt_ff[i] + 1'b1;
            if (!pd_n_s[i]) begin
              link_state_ff[i] <= LINK_OFF;
            end else if (lock_cnt_ff[i] == LOCK_W'(LOCK_CYCLES_P - 1)) begin
              link_state_ff[i] <= LINK_ACTIVE;
            end
          end
          LINK_ACTIVE: begin
            if (!pd_n_s[i]) begin
              link_state_ff[i] <= LINK_OFF;
            end
          end
          default: begin
            link_state_ff[i] <= LINK_OFF;
          end
        endcase
      end
    end
  end

  // transmit clock edge and period measurement
  assign tx_edge = tx_clk_s & ~tx_clk_d_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_clk_d_ff  <= 1'b0;
      tx_cnt_ff    <= PERIOD_ONE;
      tx_period_ff <= PERIOD_RESET;
    end else begin
      tx_clk_d_ff <= tx_clk_s;
      if (tx_edge) begin
        tx_period_ff <= tx_cnt_ff;
        tx_cnt_ff    <= PERIOD_ONE;
      end else if (tx_cnt_ff != PERIOD_MAX) begin
        tx_cnt_ff <= tx_cnt_ff + PERIOD_ONE;
      end
    end
  end

  // word capture and slot timing, slot 0 starts at the clock edge
  assign nxt_word   = tx_edge ? tx_data_s : word_ff;
  // slots run one cycle short of the last period so slot 6 still fits a period one cycle shorter
  assign nxt_tx_tmr = tx_edge ? slot_timer_t'{acc: '0, slot: FIRST_SLOT, run: 1'b1, tick: 1'b0}
                              : timer_step(tx_tmr_ff, tx_period_ff - PERIOD_ONE);
  always_ff @(posedge clk) begin
    if (rst) begin
      word_ff   <= '0;
      tx_tmr_ff <= '0;
    end else begin
      word_ff   <= nxt_word;
      tx_tmr_ff <= nxt_tx_tmr;
    end
  end

  // pair p carries bits p*7 .. p*7+6, slot order low bit first
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_tx_map
    assign nxt_tx_bits[p] = nxt_word[p * SLOTS_PER_PAIR + int'(nxt_tx_tmr.slot)];
  end

  // serial outputs: quiet while locking, floated while powered down
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_pair_true_ff <= '0;
      serial_data_pair_comp_ff <= '1;
      forwarded_clock_true_ff  <= 1'b0;
      forwarded_clock_comp_ff  <= 1'b1;
      serial_data_oe_ff        <= 1'b0;
      forwarded_clock_oe_ff    <= 1'b0;
    end else begin
      serial_data_oe_ff     <= link_state_ff[TX_SIDE] != LINK_OFF;
      forwarded_clock_oe_ff <= link_state_ff[TX_SIDE] != LINK_OFF;
      if (link_state_ff[TX_SIDE] == LINK_ACTIVE) begin
        serial_data_pair_true_ff <= nxt_tx_bits;
        serial_data_pair_comp_ff <= ~nxt_tx_bits;
        forwarded_clock_true_ff  <= tx_clk_s;
        forwarded_clock_comp_ff  <= ~tx_clk_s;
      end else begin
        serial_data_pair_true_ff <= '0;
        serial_data_pair_comp_ff <= '1;
        forwarded_clock_true_ff  <= 1'b0;
        forwarded_clock_comp_ff  <= 1'b1;
      end
    end
  end

  // receive clock edge and period measurement
  assign rx_edge = rx_clk_s & ~rx_clk_d_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_clk_d_ff  <= 1'b0;
      rx_cnt_ff    <= PERIOD_ONE;
      rx_period_ff <= PERIOD_RESET;
    end else begin
      rx_clk_d_ff <= rx_clk_s;
      if (rx_edge) begin
        rx_period_ff <= rx_cnt_ff;
        rx_cnt_ff    <= PERIOD_ONE;
      end else if (rx_cnt_ff != PERIOD_MAX) begin
        rx_cnt_ff <= rx_cnt_ff + PERIOD_ONE;
      end
    end
  end

  // sample each slot in its last cycle: timer starts one step ahead of the sender's,
  // same shortened period, so the slot 6 sample lands before the next clock edge
  assign nxt_rx_tmr = rx_edge ? slot_timer_t'{acc: ACC_STEP, slot: FIRST_SLOT, run: 1'b1, tick: 1'b0}
                              : timer_step(rx_tmr_ff, rx_period_ff - PERIOD_ONE);
  assign rx_word_done = nxt_rx_tmr.tick && (rx_tmr_ff.slot == LAST_SLOT);

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_rx_decode
    assign rx_bit[p] = rx_t_s[p] & ~rx_c_s[p];
  end

  // place sampled bits into their word positions
  always_comb begin
    nxt_rx_shift = rx_shift_ff;
    if (nxt_rx_tmr.tick) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        nxt_rx_shift[p * SLOTS_PER_PAIR + int'(rx_tmr_ff.slot)] = rx_bit[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_tmr_ff   <= '0;
      rx_shift_ff <= '0;
    end else begin
      rx_tmr_ff   <= nxt_rx_tmr;
      rx_shift_ff <= nxt_rx_shift;
    end
  end

  // parallel outputs and strobe, frozen unless locked and running
  always_ff @(posedge clk) begin
    if (rst) begin
      parallel_rx_outputs_ff    <= '0;
      recovered_output_clock_ff <= 1'b0;
    end else if (link_state_ff[RX_SIDE] == LINK_ACTIVE) begin
      if (rx_word_done) begin
        parallel_rx_outputs_ff    <= nxt_rx_shift;
        recovered_output_clock_ff <= 1'b0;
      end else if (nxt_rx_tmr.tick && rx_tmr_ff.slot == STROBE_SLOT) begin
        recovered_output_clock_ff <= 1'b1;
      end
    end
  end

  // outputs straight from flops
  assign serial_data_pair_true  = serial_data_pair_true_ff;
  assign serial_data_pair_comp  = serial_data_pair_comp_ff;
  assign serial_data_oe         = serial_data_oe_ff;
  assign forwarded_clock_true   = forwarded_clock_true_ff;
  assign forwarded_clock_comp   = forwarded_clock_comp_ff;
  assign forwarded_clock_oe     = forwarded_clock_oe_ff;
  assign parallel_rx_outputs    = parallel_rx_outputs_ff;
  assign recovered_output_clock = recovered_output_clock_ff;

  // checks on the behaviour above
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tx_word_capture: assert property (tx_edge |=> word_ff == $past(tx_data_s))
    else $error("input word not captured on clock edge");
  a_tx_pair_comp: assert property (serial_data_pair_comp_ff == ~serial_data_pair_true_ff)
    else $error("data pair lines not complementary");
  a_tx_clock_follow: assert property ((link_state_ff[TX_SIDE] == LINK_ACTIVE) |=>
      forwarded_clock_true_ff == $past(tx_clk_s) && forwarded_clock_comp_ff == ~forwarded_clock_true_ff)
    else $error("forwarded clock does not follow input clock");
  a_tx_float_off: assert property (!pd_n_s[TX_SIDE] |=> ##1 !serial_data_oe_ff && !forwarded_clock_oe_ff)
    else $error("outputs driven during power-down");
  a_rx_bit_decode: assert property (nxt_rx_tmr.tick |=>
      rx_shift_ff[$past(rx_tmr_ff.slot)] == $past(rx_t_s[0] & ~rx_c_s[0]))
    else $error("pair 0 bit not decoded into its slot");
  a_rx_strobe_low: assert property ($changed(parallel_rx_outputs_ff) |-> !recovered_output_clock_ff)
    else $error("outputs changed while strobe high");
  a_rx_freeze_down: assert property ((link_state_ff[RX_SIDE] != LINK_ACTIVE) |=>
      parallel_rx_outputs_ff == $past(parallel_rx_outputs_ff) && $stable(recovered_output_clock_ff))
    else $error("receiver outputs moved while powered down");
  a_tx_slot_start: assert property (tx_edge |=> tx_tmr_ff.slot == FIRST_SLOT && tx_tmr_ff.run ##1
      tx_tmr_ff.slot <= 3'h1)
    else $error("slot timer not restarted at clock edge");
  a_tx_quiet_lock: assert property ((link_state_ff[TX_SIDE] != LINK_ACTIVE) |=> serial_data_pair_true_ff == '0)
    else $error("data toggled before lock");
  a_rx_hold_stop: assert property ((!rx_tmr_ff.run && !rx_edge) |=> $stable(parallel_rx_outputs_ff))
    else $error("outputs changed without link clock");
  a_tx_slot_map: assert property ((link_state_ff[TX_SIDE] == LINK_ACTIVE) |=>
      serial_data_pair_true_ff[2] == word_ff[2 * SLOTS_PER_PAIR + int'(tx_tmr_ff.slot)])
    else $error("pair 2 carries wrong bit for its slot");

  c_rx_word: cover property (rx_word_done && link_state_ff[RX_SIDE] == LINK_ACTIVE);
  c_tx_powerdown: cover property (link_state_ff[TX_SIDE] == LINK_ACTIVE ##1 link_state_ff[TX_SIDE] == LINK_OFF);
  c_rx_frozen_edge: cover property (link_state_ff[RX_SIDE] == LINK_OFF && rx_edge);
  c_tx_last_slot: cover property (nxt_tx_tmr.tick && tx_tmr_ff.slot == LAST_SLOT);
endmodule

// file: tb/serdes21_cable.sv
// loopback cable model joining the transmit pairs back to the receive pairs
`timescale 1ns/1ps
module serdes21_cable
  import serdes21_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 cut,
  input  wire logic [NUM_PAIRS-1:0] d_true,
  input  wire logic [NUM_PAIRS-1:0] d_comp,
  input  wire logic                 d_oe,
  input  wire logic                 c_true,
  input  wire logic                 c_comp,
  input  wire logic                 c_oe,
  output logic      [NUM_PAIRS-1:0] r_true = 3'h0,
  output logic      [NUM_PAIRS-1:0] r_comp = 3'h7,
  output logic                      rc_true = 1'b0,
  output logic                      rc_comp = 1'b1
);
  logic [NUM_PAIRS-1:0] last_t_ff = 3'h0;
  logic [NUM_PAIRS-1:0] last_c_ff = 3'h7;
  logic                 lastk_t_ff = 1'b0;
  logic                 lastk_c_ff = 1'b1;

  // data pairs: a released line shows the inverse of its last driven level
  always_ff @(posedge clk) begin
    if (d_oe) begin
      r_true    <= d_true;
      r_comp    <= d_comp;
      last_t_ff <= d_true;
      last_c_ff <= d_comp;
    end else begin
      r_true <= ~last_t_ff;
      r_comp <= ~last_c_ff;
    end
  end

  // clock pair: a cut cable freezes the forwarded clock
  always_ff @(posedge clk) begin
    if (cut) begin
      rc_true <= rc_true;
    end else if (c_oe) begin
      rc_true    <= c_true;
      rc_comp    <= c_comp;
      lastk_t_ff <= c_true;
      lastk_c_ff <= c_comp;
    end else begin
      rc_true <= ~lastk_t_ff;
      rc_comp <= ~lastk_c_ff;
    end
  end
endmodule

// file: tb/parallel_lvds_serdes_21bit_tb.sv
// loopback testbench for the 21-bit serial link
`timescale 1ns/1ps
module parallel_lvds_serdes_21bit_tb;
  import serdes21_pkg::*;
  localparam int LOCK_SIM = 16;
  logic                 clk      = 1'b0;
  logic                 rst      = 1'b1;
  logic                 pclk     = 1'b0;
  logic                 tx_pd_n  = 1'b0;
  logic                 rx_pd_n  = 1'b0;
  logic                 cut      = 1'b0;
  logic [NUM_BITS-1:0]  tx_word  = 21'h000000;
  logic [NUM_BITS-1:0]  word_req = 21'h000000;
  logic [7:0]           acc      = 8'h00;
  logic [NUM_PAIRS-1:0] d_t, d_c, r_t, r_c;
  logic                 d_oe, c_t, c_c, c_oe, rc_t, rc_c, strobe;
  logic [NUM_BITS-1:0]  rx_word;
  int                   errors   = 0;
  int                   compares = 0;
  int                   cycles   = 0;

  serdes21 #(.LOCK_CYCLES_P(LOCK_SIM)) dut (.clk(clk), .rst(rst), .parallel_input_clock(pclk),
    .parallel_tx_inputs(tx_word), .tx_power_down_n(tx_pd_n), .serial_data_pair_true(d_t),
    .serial_data_pair_comp(d_c), .serial_data_oe(d_oe), .forwarded_clock_true(c_t),
    .forwarded_clock_comp(c_c), .forwarded_clock_oe(c_oe), .link_data_in_true(r_t),
    .link_data_in_comp(r_c), .link_clock_in_true(rc_t), .link_clock_in_comp(rc_c),
    .rx_power_down_n(rx_pd_n), .parallel_rx_outputs(rx_word), .recovered_output_clock(strobe));

  serdes21_cable cable (.clk(clk), .cut(cut), .d_true(d_t), .d_comp(d_c), .d_oe(d_oe), .c_true(c_t),
    .c_comp(c_c), .c_oe(c_oe), .r_true(r_t), .r_comp(r_c), .rc_true(rc_t), .rc_comp(rc_c));

  always #5 clk = ~clk;

  // 125 ns parallel clock in half-ns steps; word changes on its falling edge
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (acc + 8'h14 >= 8'h7D) begin
      acc  <= acc + 8'h14 - 8'h7D;
      pclk <= ~pclk;
      if (pclk) begin
        tx_word <= word_req;
      end
    end else begin
      acc <= acc + 8'h14;
    end
    if (cycles == 20000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic check(input logic [NUM_BITS-1:0] seen, input logic [NUM_BITS-1:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wait_strobe();
    logic prev;
    logic ok;
    prev = strobe;
    ok   = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge clk);
      #1;
      ok   = (strobe === 1'b1 && prev === 1'b0);
      prev = strobe;
    end
    if (!ok) begin
      check(1'b0, 1'b1, "strobe missing");
    end
  endtask

  task automatic send_word(input logic [NUM_BITS-1:0] w);
    word_req = w;
    repeat (4) wait_strobe();
    check(rx_word, w, "word");
    check(d_c ^ d_t, 3'h7, "data comp");
    check(c_c ^ c_t, 1'b1, "clock comp");
  endtask

  task automatic expect_oe(input int n, input logic v);
    repeat (n) @(posedge clk);
    #1;
    check(d_oe, v, "data oe");
    check(c_oe, v, "clock oe");
  endtask

  // after power-down release: driven but quiet while locking, then running
  task automatic expect_lock();
    expect_oe(2, 1'b0);
    expect_oe(8, 1'b1);
    check(c_t, 1'b0, "clock quiet while locking");
    check(d_t, 3'h0, "data quiet while locking");
    expect_oe(30, 1'b1);
  endtask

  task automatic t_reset();
    check(d_c, 3'h7, "reset comp");
    check(rx_word, 21'h000000, "reset word");
    check(strobe, 1'b0, "reset strobe");
    expect_oe(8, 1'b0);
  endtask

  task automatic t_power_up();
    @(posedge clk);
    tx_pd_n <= 1'b1;
    rx_pd_n <= 1'b1;
    expect_lock();
  endtask

  task automatic t_words();
    for (int b = 0; b < NUM_BITS; b++) begin
      send_word(21'h000001 << b);
    end
    send_word(21'h155555);
    send_word(21'h0F0F0F);
  endtask

  task automatic t_rx_hold();
    send_word(21'h12A5C3);
    @(posedge clk);
    rx_pd_n <= 1'b0;
    word_req = 21'h0D3E61;
    repeat (80) @(posedge clk);
    check(rx_word, 21'h12A5C3, "held word");
    rx_pd_n <= 1'b1;
    repeat (10) @(posedge clk);
    check(rx_word, 21'h12A5C3, "word while locking");
    send_word(21'h0D3E61);
  endtask

  task automatic t_cut();
    send_word(21'h1C0F33);
    do @(posedge clk); while (c_t !== 1'b0);
    cut <= 1'b1;
    word_req = 21'h03F0CC;
    repeat (100) @(posedge clk);
    check(rx_word, 21'h1C0F33, "word after cut");
    cut <= 1'b0;
    send_word(21'h03F0CC);
  endtask

  task automatic t_tx_off();
    @(posedge clk);
    tx_pd_n <= 1'b0;
    expect_oe(6, 1'b0);
    @(posedge clk);
    tx_pd_n <= 1'b1;
    expect_lock();
    send_word(21'h1E1E1E);
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_power_up();
    t_words();
    t_rx_hold();
    t_cut();
    t_tx_off();
    stop_test();
  end
endmodule
